//--- rtl/au_pkg.sv
// package: register map, field layout and carrier types of the transceiver
package au_pkg;
    // register byte offsets
    localparam logic [11:0] AU_OFS_CTRL1 = 12'h000;
    localparam logic [11:0] AU_OFS_CTRL2 = 12'h004;
    localparam logic [11:0] AU_OFS_IER   = 12'h008;
    localparam logic [11:0] AU_OFS_BAUD_DIVIDER_INTEGER  = 12'h00C;
    localparam logic [11:0] AU_OFS_BAUD_DIVIDER_FRACTION  = 12'h010;
    localparam logic [11:0] AU_OFS_ISR   = 12'h01C;
    localparam logic [11:0] AU_OFS_ICR   = 12'h020;
    localparam logic [11:0] AU_OFS_RDR   = 12'h024;
    localparam logic [11:0] AU_OFS_TDR   = 12'h028;
    // control register 1 fields
    localparam int AU_C1_W      = 8;
    localparam int AU_C1_TRANSMIT_ENABLE_BIT   = 0;
    localparam int AU_C1_RECEIVE_ENABLE_BIT   = 1;
    localparam int AU_C1_OVER   = 2;
    localparam int AU_C1_PAR_LO = 3;
    localparam int AU_C1_STOP   = 5;
    localparam int AU_C1_START  = 6;
    localparam int AU_C1_SYNC   = 7;
    // control register 2 fields
    localparam int AU_C2_W      = 4;
    localparam int AU_C2_TRANSMIT_DMA_ENABLE  = 0;
    localparam int AU_C2_RECEIVE_DMA_ENABLE  = 1;
    localparam int AU_C2_SRC_LO = 2;
    // flag positions, shared by status, enable and clear registers; busy is in status only
    localparam int AU_FLAG_W    = 5;
    localparam int AU_F_TXE     = 0;
    localparam int AU_F_TC      = 1;
    localparam int AU_F_RC      = 2;
    localparam int AU_F_FE      = 3;
    localparam int AU_F_PE      = 4;
    localparam int AU_F_BUSY    = 5;
    // reset values
    localparam logic [AU_C1_W-1:0]   AU_RST_CTRL1 = 8'h00;
    localparam logic [AU_C2_W-1:0]   AU_RST_CTRL2 = 4'h0;
    localparam logic [AU_FLAG_W-1:0] AU_RST_IER   = 5'h00;
    localparam logic [AU_FLAG_W-1:0] AU_RST_FLAGS = 5'h01;
    localparam logic [15:0]          AU_RST_BAUD_DIVIDER_INTEGER  = 16'h0000;
    localparam logic [3:0]           AU_RST_BAUD_DIVIDER_FRACTION  = 4'h0;
    // samples per bit
    localparam logic [4:0] AU_OSR16 = 5'h10;
    localparam logic [4:0] AU_OSR8  = 5'h08;
    // parity select codes
    localparam logic [1:0] AU_PAR_NONE = 2'h0;
    localparam logic [1:0] AU_PAR_ODD  = 2'h2;
    // dma trigger sources, used as index of the request vector
    localparam logic [7:0] AU_TRIG_RX = 8'h00;
    localparam logic [7:0] AU_TRIG_TX = 8'h01;

    typedef struct packed {
        logic [11:0] paddr;
        logic        pwrite;
        logic [31:0] pwdata;
        logic        psel;
        logic        penable;
    } au_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } au_apb_rsp_type;

    typedef enum logic [2:0] {
        AU_IDLE  = 3'b000,
        AU_START = 3'b001,
        AU_DATA  = 3'b010,
        AU_PAR   = 3'b011,
        AU_STOP  = 3'b100
    } au_state_type;
endpackage

//--- rtl/au_baud.sv
// fractional baud generator producing the oversampling tick
`timescale 1ns/1ps
`default_nettype none
module au_baud #(
    parameter int INT_W  = 16,
    parameter int FRAC_W = 4
) (
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic [INT_W-1:0]  div_int_i,
    input  wire logic [FRAC_W-1:0] div_frac_i,
    output logic                   tick_o
);
    logic [INT_W:0]   cnt_r;
    logic [INT_W:0]   cnt_nxt;
    logic [FRAC_W-1:0] acc_r;
    logic [FRAC_W-1:0] acc_nxt;
    wire  [FRAC_W:0]  acc_sum;
    wire  [INT_W:0]   period;
    wire  [INT_W:0]   reload;

    // integer part plus carry of the fraction accumulator
    assign acc_sum = {1'b0, acc_r} + {1'b0, div_frac_i};
    assign period  = (div_int_i == '0) ? (INT_W+1)'(1) : {1'b0, div_int_i};
    assign reload  = period - (INT_W+1)'(1) + (INT_W+1)'(acc_sum[FRAC_W]);
    assign tick_o  = (cnt_r == '0);
    assign cnt_nxt = tick_o ? reload : cnt_r - (INT_W+1)'(1);
    assign acc_nxt = tick_o ? acc_sum[FRAC_W-1:0] : acc_r;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= '0;
            acc_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            acc_r <= acc_nxt;
        end
    end
endmodule
`default_nettype wire

//--- rtl/au_uart.sv
// full-duplex asynchronous transceiver with apb registers and dma requests
`timescale 1ns/1ps
`default_nettype none
module au_uart (
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire au_pkg::au_apb_req_type apb_i,
    output au_pkg::au_apb_rsp_type apb_o,
    input  wire logic              rxd_i,
    output logic                   txd_o,
    output logic                   irq_o,
    output logic [1:0]             dma_req_o
);
    import au_pkg::*;

    function automatic logic bit_end(input logic [4:0] cnt,
                                     input logic [4:0] osr);
        bit_end = (cnt == osr - 5'h01);
    endfunction

    function automatic logic par_of(input logic [7:0] d, input logic odd);
        par_of = (^d) ^ odd;
    endfunction

    // configuration and status storage
    logic [AU_C1_W-1:0]   ctrl1_r;
    logic [AU_C2_W-1:0]   ctrl2_r;
    logic [AU_FLAG_W-1:0] ier_r;
    logic [15:0]          baud_divider_integer_r;
    logic [3:0]           baud_divider_fraction_r;
    logic [AU_FLAG_W-1:0] flags_r;
    logic [AU_FLAG_W-1:0] flags_nxt;
    logic [7:0]           rdr_r;
    logic                 rdr_full_r;
    logic [7:0]           tdr_r;
    logic                 tx_pend_r;
    logic [31:0]          prdata_r;
    logic [31:0]          rd_mux;

    // bus decode
    wire access   = apb_i.psel & apb_i.penable;
    wire setup    = apb_i.psel & ~apb_i.penable;
    wire wr       = access & apb_i.pwrite;
    wire rd       = access & ~apb_i.pwrite;
    wire hit_c1   = (apb_i.paddr == AU_OFS_CTRL1);
    wire hit_c2   = (apb_i.paddr == AU_OFS_CTRL2);
    wire hit_ier  = (apb_i.paddr == AU_OFS_IER);
    wire hit_bri  = (apb_i.paddr == AU_OFS_BAUD_DIVIDER_INTEGER);
    wire hit_brf  = (apb_i.paddr == AU_OFS_BAUD_DIVIDER_FRACTION);
    wire hit_isr  = (apb_i.paddr == AU_OFS_ISR);
    wire hit_icr  = (apb_i.paddr == AU_OFS_ICR);
    wire hit_rdr  = (apb_i.paddr == AU_OFS_RDR);
    wire hit_tdr  = (apb_i.paddr == AU_OFS_TDR);
    wire mapped   = hit_c1 | hit_c2 | hit_ier | hit_bri | hit_brf |
                    hit_isr | hit_icr | hit_rdr | hit_tdr;
    wire tdr_wr   = wr & hit_tdr;
    wire icr_wr   = wr & hit_icr;
    wire rdr_rd   = rd & hit_rdr;

    // configuration fields
    wire       async_mode = ~ctrl1_r[AU_C1_SYNC];
    wire       tx_run     = async_mode & ctrl1_r[AU_C1_TRANSMIT_ENABLE_BIT];
    wire       rx_run     = async_mode & ctrl1_r[AU_C1_RECEIVE_ENABLE_BIT];
    wire [1:0] par_sel    = ctrl1_r[AU_C1_PAR_LO +: 2];
    wire       par_on     = (par_sel != AU_PAR_NONE);
    wire       par_odd    = (par_sel == AU_PAR_ODD);
    wire       stop_two   = ctrl1_r[AU_C1_STOP];
    wire [4:0] osr        = ctrl1_r[AU_C1_OVER] ? AU_OSR8
                                                : AU_OSR16;
    wire [4:0] half_osr   = {1'b0, osr[4:1]};

    // oversampling tick, always from the bus clock
    logic tick;
    au_baud #(
        .INT_W  (16),
        .FRAC_W (4)
    ) u_baud (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .div_int_i  (baud_divider_integer_r),
        .div_frac_i (baud_divider_fraction_r),
        .tick_o     (tick)
    );

    // receive line synchroniser and filter
    logic rx_s1_r;
    logic rx_s2_r;
    logic rx_s3_r;
    logic rx_line_r;
    logic rx_prev_r;
    wire  rx_line_nxt = (rx_s2_r == rx_s3_r) ? rx_s3_r : rx_line_r;
    wire  rx_fall     = rx_prev_r & ~rx_line_r;
    wire  rx_start    = ctrl1_r[AU_C1_START] ? ~rx_line_r
                                             : rx_fall;

    // receiver
    au_state_type rx_st_r;
    au_state_type rx_st_nxt;
    logic [4:0]   rx_cnt_r;
    logic [4:0]   rx_cnt_nxt;
    logic [2:0]   rx_bit_r;
    logic [2:0]   rx_bit_nxt;
    logic [7:0]   rx_sh_r;
    logic [7:0]   rx_sh_nxt;
    logic         rx_pe_r;
    logic         rx_pe_nxt;
    logic         rx_fe_r;
    logic         rx_fe_nxt;
    logic         rx_s2nd_r;
    logic         rx_s2nd_nxt;
    logic         rx_done;

    always_comb begin
        rx_st_nxt   = rx_st_r;
        rx_cnt_nxt  = rx_cnt_r;
        rx_bit_nxt  = rx_bit_r;
        rx_sh_nxt   = rx_sh_r;
        rx_pe_nxt   = rx_pe_r;
        rx_fe_nxt   = rx_fe_r;
        rx_s2nd_nxt = rx_s2nd_r;
        rx_done     = 1'b0;
        if (!rx_run) begin
            rx_st_nxt = AU_IDLE;
        end else begin
            case (rx_st_r)
                AU_IDLE: begin
                    if (rx_start) begin
                        rx_st_nxt   = AU_START;
                        rx_cnt_nxt  = '0;
                        rx_pe_nxt   = 1'b0;
                        rx_fe_nxt   = 1'b0;
                        rx_s2nd_nxt = 1'b0;
                    end
                end
                AU_START: begin
                    if (tick) begin
                        if (rx_cnt_r == half_osr - 5'h01) begin
                            rx_cnt_nxt = '0;
                            rx_bit_nxt = '0;
                            rx_st_nxt  = rx_line_r ? AU_IDLE : AU_DATA;
                        end else begin
                            rx_cnt_nxt = rx_cnt_r + 5'h01;
                        end
                    end
                end
                AU_DATA: begin
                    if (tick) begin
                        rx_cnt_nxt = rx_cnt_r + 5'h01;
                        if (bit_end(rx_cnt_r, osr)) begin
                            rx_cnt_nxt = '0;
                            rx_sh_nxt  = {rx_line_r, rx_sh_r[7:1]};
                            rx_bit_nxt = rx_bit_r + 3'h1;
                            if (rx_bit_r == 3'h7) begin
                                rx_st_nxt = par_on ? AU_PAR : AU_STOP;
                            end
                        end
                    end
                end
                AU_PAR: begin
                    if (tick) begin
                        rx_cnt_nxt = rx_cnt_r + 5'h01;
                        if (bit_end(rx_cnt_r, osr)) begin
                            rx_cnt_nxt = '0;
                            rx_pe_nxt  = par_of(rx_sh_r, par_odd)
                                         ^ rx_line_r;
                            rx_st_nxt  = AU_STOP;
                        end
                    end
                end
                AU_STOP: begin
                    if (tick) begin
                        rx_cnt_nxt = rx_cnt_r + 5'h01;
                        if (bit_end(rx_cnt_r, osr)) begin
                            rx_cnt_nxt = '0;
                            rx_fe_nxt  = rx_fe_r | ~rx_line_r;
                            if (stop_two && !rx_s2nd_r) begin
                                rx_s2nd_nxt = 1'b1;
                            end else begin
                                rx_done   = 1'b1;
                                rx_st_nxt = AU_IDLE;
                            end
                        end
                    end
                end
                default: rx_st_nxt = AU_IDLE;
            endcase
        end
    end

    // transmitter
    au_state_type tx_st_r;
    au_state_type tx_st_nxt;
    logic [4:0]   tx_cnt_r;
    logic [4:0]   tx_cnt_nxt;
    logic [2:0]   tx_bit_r;
    logic [2:0]   tx_bit_nxt;
    logic [7:0]   tx_sh_r;
    logic [7:0]   tx_sh_nxt;
    logic         tx_par_r;
    logic         tx_par_nxt;
    logic         tx_s2nd_r;
    logic         tx_s2nd_nxt;
    logic         txd_nxt;
    logic         tx_load;
    logic         tx_end;

    always_comb begin
        tx_st_nxt   = tx_st_r;
        tx_cnt_nxt  = tx_cnt_r;
        tx_bit_nxt  = tx_bit_r;
        tx_sh_nxt   = tx_sh_r;
        tx_par_nxt  = tx_par_r;
        tx_s2nd_nxt = tx_s2nd_r;
        tx_load     = 1'b0;
        tx_end      = 1'b0;
        case (tx_st_r)
            AU_IDLE: begin
                if (tx_run && tx_pend_r) begin
                    tx_load     = 1'b1;
                    tx_sh_nxt   = tdr_r;
                    tx_par_nxt  = par_of(tdr_r, par_odd);
                    tx_cnt_nxt  = '0;
                    tx_bit_nxt  = '0;
                    tx_s2nd_nxt = 1'b0;
                    tx_st_nxt   = AU_START;
                end
            end
            AU_START: begin
                if (tick) begin
                    tx_cnt_nxt = tx_cnt_r + 5'h01;
                    if (bit_end(tx_cnt_r, osr)) begin
                        tx_cnt_nxt = '0;
                        tx_st_nxt  = AU_DATA;
                    end
                end
            end
            AU_DATA: begin
                if (tick) begin
                    tx_cnt_nxt = tx_cnt_r + 5'h01;
                    if (bit_end(tx_cnt_r, osr)) begin
                        tx_cnt_nxt = '0;
                        tx_sh_nxt  = {1'b0, tx_sh_r[7:1]};
                        tx_bit_nxt = tx_bit_r + 3'h1;
                        if (tx_bit_r == 3'h7) begin
                            tx_st_nxt = par_on ? AU_PAR : AU_STOP;
                        end
                    end
                end
            end
            AU_PAR: begin
                if (tick) begin
                    tx_cnt_nxt = tx_cnt_r + 5'h01;
                    if (bit_end(tx_cnt_r, osr)) begin
                        tx_cnt_nxt = '0;
                        tx_st_nxt  = AU_STOP;
                    end
                end
            end
            AU_STOP: begin
                if (tick) begin
                    tx_cnt_nxt = tx_cnt_r + 5'h01;
                    if (bit_end(tx_cnt_r, osr)) begin
                        tx_cnt_nxt = '0;
                        if (stop_two && !tx_s2nd_r) begin
                            tx_s2nd_nxt = 1'b1;
                        end else begin
                            tx_end    = 1'b1;
                            tx_st_nxt = AU_IDLE;
                        end
                    end
                end
            end
            default: tx_st_nxt = AU_IDLE;
        endcase
    end

    always_comb begin
        case (tx_st_nxt)
            AU_START: txd_nxt = 1'b0;
            AU_DATA:  txd_nxt = tx_sh_nxt[0];
            AU_PAR:   txd_nxt = tx_par_nxt;
            default:  txd_nxt = 1'b1;
        endcase
    end

    // flag update, set wins over clear
    wire [AU_FLAG_W-1:0] flag_set = {rx_done & rx_pe_nxt,
                                     rx_done & rx_fe_nxt,
                                     rx_done,
                                     tx_end,
                                     tx_load};
    wire [AU_FLAG_W-1:0] icr_clr  = icr_wr ? ~apb_i.pwdata[AU_FLAG_W-1:0]
                                           : '0;
    wire [AU_FLAG_W-1:0] tdr_clr  = AU_FLAG_W'(tdr_wr);
    assign flags_nxt = (flags_r & ~(icr_clr | tdr_clr)) | flag_set;

    wire tx_busy = (tx_st_r != AU_IDLE) | tx_pend_r;

    // read data mux
    always_comb begin
        rd_mux = '0;
        case (1'b1)
            hit_c1:  rd_mux[AU_C1_W-1:0]   = ctrl1_r;
            hit_c2:  rd_mux[AU_C2_W-1:0]   = ctrl2_r;
            hit_ier: rd_mux[AU_FLAG_W-1:0] = ier_r;
            hit_bri: rd_mux[15:0]          = baud_divider_integer_r;
            hit_brf: rd_mux[3:0]           = baud_divider_fraction_r;
            hit_isr: rd_mux[AU_F_BUSY:0]   = {tx_busy, flags_r};
            hit_rdr: rd_mux[7:0]           = rdr_r;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl1_r  <= AU_RST_CTRL1;
            ctrl2_r  <= AU_RST_CTRL2;
            ier_r    <= AU_RST_IER;
            baud_divider_integer_r   <= AU_RST_BAUD_DIVIDER_INTEGER;
            baud_divider_fraction_r   <= AU_RST_BAUD_DIVIDER_FRACTION;
            prdata_r <= '0;
        end else begin
            if (wr && hit_c1) ctrl1_r <= apb_i.pwdata[AU_C1_W-1:0];
            if (wr && hit_c2) ctrl2_r <= apb_i.pwdata[AU_C2_W-1:0];
            if (wr && hit_ier) ier_r <= apb_i.pwdata[AU_FLAG_W-1:0];
            if (wr && hit_bri) baud_divider_integer_r <= apb_i.pwdata[15:0];
            if (wr && hit_brf) baud_divider_fraction_r <= apb_i.pwdata[3:0];
            if (setup) prdata_r <= rd_mux;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flags_r    <= AU_RST_FLAGS;
            rdr_r      <= '0;
            rdr_full_r <= 1'b0;
            tdr_r      <= '0;
            tx_pend_r  <= 1'b0;
        end else begin
            flags_r    <= flags_nxt;
            rdr_full_r <= (rdr_full_r & ~rdr_rd) | rx_done;
            tx_pend_r  <= (tx_pend_r & ~tx_load) | tdr_wr;
            if (rx_done) rdr_r <= rx_sh_r;
            if (tdr_wr) tdr_r <= apb_i.pwdata[7:0];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_s1_r   <= 1'b1;
            rx_s2_r   <= 1'b1;
            rx_s3_r   <= 1'b1;
            rx_line_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rx_s1_r   <= rxd_i;
            rx_s2_r   <= rx_s1_r;
            rx_s3_r   <= rx_s2_r;
            rx_line_r <= rx_line_nxt;
            rx_prev_r <= rx_line_r;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_st_r   <= AU_IDLE;
            rx_cnt_r  <= '0;
            rx_bit_r  <= '0;
            rx_sh_r   <= '0;
            rx_pe_r   <= 1'b0;
            rx_fe_r   <= 1'b0;
            rx_s2nd_r <= 1'b0;
        end else begin
            rx_st_r   <= rx_st_nxt;
            rx_cnt_r  <= rx_cnt_nxt;
            rx_bit_r  <= rx_bit_nxt;
            rx_sh_r   <= rx_sh_nxt;
            rx_pe_r   <= rx_pe_nxt;
            rx_fe_r   <= rx_fe_nxt;
            rx_s2nd_r <= rx_s2nd_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_st_r   <= AU_IDLE;
            tx_cnt_r  <= '0;
            tx_bit_r  <= '0;
            tx_sh_r   <= '0;
            tx_par_r  <= 1'b0;
            tx_s2nd_r <= 1'b0;
            txd_o     <= 1'b1;
        end else begin
            tx_st_r   <= tx_st_nxt;
            tx_cnt_r  <= tx_cnt_nxt;
            tx_bit_r  <= tx_bit_nxt;
            tx_sh_r   <= tx_sh_nxt;
            tx_par_r  <= tx_par_nxt;
            tx_s2nd_r <= tx_s2nd_nxt;
            txd_o     <= txd_nxt;
        end
    end

    // outputs
    assign irq_o = |(flags_r & ier_r);
    assign dma_req_o[AU_TRIG_TX[0]] = ctrl2_r[AU_C2_TRANSMIT_DMA_ENABLE] & tx_run
                                      & flags_r[AU_F_TXE];
    assign dma_req_o[AU_TRIG_RX[0]] = ctrl2_r[AU_C2_RECEIVE_DMA_ENABLE]
                                      & rdr_full_r;
    assign apb_o = '{prdata:  prdata_r,
                     pready:  1'b1,
                     pslverr: access & ~mapped};
endmodule
`default_nettype wire

//--- bench/au_uart_assertions.sv
// checker: port-level assertions of the transceiver
`timescale 1ns/1ps
`default_nettype none
module au_uart_assertions (
    input wire logic                   clk_i,
    input wire logic                   rstn_i,
    input wire au_pkg::au_apb_req_type apb_i,
    input wire au_pkg::au_apb_rsp_type apb_o,
    input wire logic                   rxd_i,
    input wire logic                   txd_o,
    input wire logic                   irq_o,
    input wire logic [1:0]             dma_req_o
);
    import au_pkg::*;
    logic        acc;
    logic        wr;
    logic [11:0] a;
    assign acc = apb_i.psel && apb_i.penable;
    assign wr  = acc && apb_i.pwrite;
    assign a   = apb_i.paddr;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    AST_TXREQ_DROP:
        assert property (wr && a == AU_OFS_TDR |=> !dma_req_o[1])
        else $error("tx request held after data write");
    AST_RXREQ_DROP:
        assert property (acc && !apb_i.pwrite && a == AU_OFS_RDR
                         |=> ##1 !dma_req_o[0])
        else $error("rx request held after data read");
    AST_TRANSMIT_DMA_ENABLE_OFF:
        assert property (wr && a == AU_OFS_CTRL2 && !apb_i.pwdata[0]
                         |=> ##1 !dma_req_o[1])
        else $error("tx request while disabled");
    AST_RECEIVE_DMA_ENABLE_OFF:
        assert property (wr && a == AU_OFS_CTRL2 && !apb_i.pwdata[1]
                         |=> ##1 !dma_req_o[0])
        else $error("rx request while disabled");
    AST_IRQ_FALL:
        assert property ($fell(irq_o) |-> $past(wr) || $past(wr, 2))
        else $error("interrupt dropped without a write");
    AST_CLR_ONES:
        assert property (wr && a == AU_OFS_ICR && apb_i.pwdata[4:0] == 5'h1F
                         |=> !$fell(irq_o) ##1 !$fell(irq_o))
        else $error("clear with ones changed a flag");
    AST_LOW_RUN:
        assert property ($fell(txd_o) |-> !txd_o [*8])
        else $error("serial bit shorter than sample count");
    AST_TDR_RD0:
        assert property (acc && !apb_i.pwrite && a == AU_OFS_TDR
                         |-> apb_o.prdata == 32'h0)
        else $error("transmit data reads nonzero");
    cover property (wr && a == AU_OFS_TDR);
    cover property ($rose(dma_req_o[0]));
    cover property ($rose(irq_o));
endmodule
bind au_uart au_uart_assertions u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
    .apb_i(apb_i), .apb_o(apb_o), .rxd_i(rxd_i), .txd_o(txd_o),
    .irq_o(irq_o), .dma_req_o(dma_req_o));
`default_nettype wire

//--- bench/au_remote.sv
// remote serial device: frame sender and transmit-line watcher
`timescale 1ns/1ps
`default_nettype none
module au_remote #(
    parameter int BIT = 32
) (
    input  wire logic clk_i,
    input  wire logic txd_i,
    output logic      rxd_o
);
    logic [7:0] rx_byte;
    initial rxd_o = 1'b1;
    // start low, eight bits lsb first, one stop bit
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            rxd_o <= f[i];
            repeat (BIT - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        rxd_o <= 1'b1;
    endtask
    // transceiver transmit line, sampled mid-bit
    always begin
        @(negedge txd_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_i);
            rx_byte[i] = txd_i;
        end
        repeat (BIT) @(posedge clk_i);
    end
endmodule
`default_nettype wire

//--- bench/au_uart_bench.sv
// testbench: register-level tests of the transceiver
`timescale 1ns/1ps
`default_nettype none
module au_uart_bench;
    import au_pkg::*;
    logic           clk_i;
    logic           rstn_i;
    logic           rxd;
    logic           txd;
    logic           irq;
    logic [1:0]     dma;
    au_apb_req_type req;
    au_apb_rsp_type rsp;
    logic [31:0]    rdv;
    logic           err;
    int             n_fail;
    int             checks_done;
    au_uart dut (.clk_i(clk_i), .rstn_i(rstn_i), .apb_i(req), .apb_o(rsp),
        .rxd_i(rxd), .txd_o(txd), .irq_o(irq), .dma_req_o(dma));
    au_remote #(.BIT(32)) rem (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd));
    always #5 clk_i = ~clk_i;
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk_i);
        req <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
        @(posedge clk_i);
        req.penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (rsp.pready !== 1'b1 && i < 50);
        rdv = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (i >= 50) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdv, exp);
    endtask
    task automatic wait_flag(input logic [4:0] m);
        int i;
        for (i = 0; i < 400; i++) begin
            apb(1'b0, AU_OFS_ISR, 32'h0);
            if ((rdv[4:0] & m) === m) break;
        end
        if (i == 400) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    initial begin
        clk_i = 1'b0;
        rstn_i = 1'b0;
        req = '0;
        n_fail = 0;
        checks_done = 0;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(AU_OFS_ISR, 32'h1);
        apb(1'b0, 12'h0FC, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        apb(1'b1, AU_OFS_BAUD_DIVIDER_INTEGER, 32'h2);
        apb(1'b1, AU_OFS_CTRL1, 32'h3);
        apb(1'b1, AU_OFS_ICR, 32'h0);
        rd(AU_OFS_ISR, 32'h0);
        apb(1'b1, AU_OFS_IER, 32'h1);
        apb(1'b1, AU_OFS_TDR, 32'hA5);
        rd(AU_OFS_ISR, 32'h21);
        chk({31'h0, irq}, 32'h1);
        rd(AU_OFS_TDR, 32'h0);
        wait_flag(5'h02);
        chk({24'h0, rem.rx_byte}, 32'hA5);
        rd(AU_OFS_ISR, 32'h3);
        $display("test transmit done");
        apb(1'b1, AU_OFS_IER, 32'h4);
        rem.send(8'h3C, 1'b1);
        wait_flag(5'h04);
        rd(AU_OFS_ISR, 32'h7);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, AU_OFS_ICR, 32'h1F);
        rd(AU_OFS_ISR, 32'h7);
        rd(AU_OFS_RDR, 32'h3C);
        apb(1'b1, AU_OFS_ICR, 32'h1B);
        rd(AU_OFS_ISR, 32'h3);
        chk({31'h0, irq}, 32'h0);
        $display("test receive done");
        rem.send(8'h5A, 1'b0);
        wait_flag(5'h04);
        rem.send(8'hC3, 1'b1);
        rd(AU_OFS_ISR, 32'hF);
        apb(1'b1, AU_OFS_CTRL2, 32'h3);
        repeat (2) @(negedge clk_i);
        chk({30'h0, dma}, 32'h3);
        rd(AU_OFS_RDR, 32'hC3);
        repeat (2) @(negedge clk_i);
        chk({30'h0, dma}, 32'h2);
        apb(1'b1, AU_OFS_CTRL2, 32'h0);
        repeat (2) @(negedge clk_i);
        chk({30'h0, dma}, 32'h0);
        apb(1'b1, AU_OFS_CTRL1, 32'h13);
        apb(1'b1, AU_OFS_ICR, 32'h0);
        rem.send(8'h3C, 1'b0);
        wait_flag(5'h04);
        rd(AU_OFS_ISR, 32'h14);
        apb(1'b1, AU_OFS_CTRL1, 32'h1);
        apb(1'b1, AU_OFS_ICR, 32'h0);
        rem.send(8'h11, 1'b1);
        rd(AU_OFS_ISR, 32'h0);
        $display("test dma and disable done");
        report_and_stop();
    end
endmodule
`default_nettype wire
